// file: src/hbridge_regs_defines.vh
/*
  Register map, field positions, reset values and timing figures for the
  H-bridge configuration and status register bank.
  Assumes a 40 MHz internal clock and a 16-bit serial command word.
*/
`ifndef HBRIDGE_REGS_DEFINES_VH
`define HBRIDGE_REGS_DEFINES_VH

// register addresses (5-bit serial address field)
`define ADDR_FAULT_SUMMARY 5'h00
`define ADDR_HB_DIAG 5'h01
`define ADDR_DRIVE_MODE 5'h02
`define ADDR_PROT_POLICY 5'h03
`define ADDR_LOCK_DRIVE 5'h04
`define ADDR_LOAD_LIMIT 5'h05

// reset values
`define RST_DRIVE_MODE 8'h51
`define RST_PROT_POLICY 8'h0C
`define RST_LOCK_DRIVE 8'h40
`define RST_LOAD_LIMIT 8'h08

// lock codes
`define LOCK_CODE_LOCK 3'h3
`define LOCK_CODE_OPEN 3'h4

// bridge mode codes
`define MODE_PHASE_ENABLE_MODE 2'h0
`define MODE_PWM 2'h1
`define MODE_INDEP 2'h2
`define MODE_HIZ 2'h3

// overcurrent policy codes
`define OCP_LATCH 2'h0
`define OCP_RETRY 2'h1
`define OCP_REPORT 2'h2
`define OCP_IGNORE 2'h3

// serial frame layout
`define FRAME_BITS 5'd16
`define CMD_RW_BIT 14
`define CMD_ADDR_HI 13
`define CMD_ADDR_LO 9
`define STATUS_TOP 2'h3

// timing
`define CLK_MHZ 40
`define RETRY_BASE_US 500
`define OL_SHORT_US 300
`define OL_LONG_US 1200

`endif

// file: src/hbridge_config_status_regs.v
/*
  H-bridge configuration and status register bank with its 16-bit serial
  slave port (mode 1: capture on falling edge, drive on rising edge).
  Assumes fault detector inputs are synchronous to ref_clk; serial pins
  and bridge input pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`include "hbridge_regs_defines.vh"

// Notes on behaviour
// [R01] host writes only addresses two to five
// [R02] summary status: global error plus six fault flags
// [R03] diagnostic bits 7,6: bridge open load
// [R04] diagnostic bits 5,4: bridge current regulating
// [R05] diagnostic bits 3..0: per-switch overcurrent
// [R06] off-time code bits 7:6, reset 01
// [R07] bit 5 selects pins or soft drive
// [R08] slew code bits 4:2, reset 100
// [R09] bridge mode bits 1:0, reset PWM
// [R10] optional regulation and warning error reporting
// [R11] thermal shutdown latched or auto recovering
// [R12] pump undervoltage fault can be disabled
// [R13] overcurrent retry interval, reset 4 ms
// [R14] overcurrent policy: latch, retry, report, ignore
// [R15] fault clear bit self-clears after write
// [R16] lock code 011 freezes drive mode register
// [R17] independent mode: per-bridge high impedance bits
// [R18] soft drive bits replace input pins
// [R19] standby load test bit clears when done
// [R20] load test delay 300 us or 1.2 ms
// [R21] active load test enable bit
// [R22] trip level and regulation disable fields
// [R23] command: read bit, address, data byte
// [R24] response: status byte then register content
// [R25] writes to status registers change nothing
module hbridge_config_status_regs #(
  parameter RETRY_BASE_CYCLES = `RETRY_BASE_US * `CLK_MHZ,
  parameter OL_SHORT_CYCLES = `OL_SHORT_US * `CLK_MHZ,
  parameter OL_LONG_CYCLES = `OL_LONG_US * `CLK_MHZ
) (
  input wire ref_clk, // 40 MHz internal clock
  input wire rst, // synchronous reset, active high
  input wire scs_n_pin, // serial chip select, active low
  input wire sclk_pin, // serial clock
  input wire sdi_pin, // serial data in
  output wire sdo, // serial data out
  output wire sdo_oe_n, // sdo drive enable, low while driving
  input wire in_a_pin, // bridge control input a
  input wire in_b_pin, // bridge control input b
  input wire overheat_warning_in, // overtemperature warning detector
  input wire supply_uv_in, // supply undervoltage detector
  input wire pump_uv_in, // charge pump undervoltage detector
  input wire thermal_in, // overtemperature shutdown detector
  input wire [3:0] overcurrent_in, // h1,l1,h2,l2 overcurrent detectors
  input wire [1:0] open_load_in, // bridge1,bridge2 open load detectors
  input wire [1:0] regulating_in, // bridge1,bridge2 current regulation
  output reg error_output_pin_n, // error output, low on error
  output reg drive_a, // selected bridge control a
  output reg drive_b, // selected bridge control b
  output reg bridge1_hiz, // half bridge 1 high impedance
  output reg bridge2_hiz, // half bridge 2 high impedance
  output reg bridge_fault_off, // protection shutting bridge down
  output reg [1:0] bridge_mode, // bridge input mode
  output reg [1:0] off_time_select, // off-time code
  output reg [2:0] slew_code, // edge rate code
  output reg [1:0] trip_current_level, // trip level code
  output reg [1:0] regulation_enable, // bridge1,bridge2 regulated
  output reg active_load_test_enable // open load check while active
);

  function is_ctrl_addr;
    input [4:0] a;
    begin
      is_ctrl_addr = (a >= `ADDR_DRIVE_MODE) && (a <= `ADDR_LOAD_LIMIT);
    end
  endfunction

  // pin synchronisers: sclk, scs_n, sdi, in_a, in_b
  wire [4:0] pin_raw;
  reg [4:0] pin_s1_q;
  reg [4:0] pin_s2_q;
  reg [4:0] pin_s3_q;
  reg [4:0] pin_f_q;
  wire [4:0] pin_chg;
  assign pin_raw = {in_b_pin, in_a_pin, sdi_pin, scs_n_pin, sclk_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      assign pin_chg[gi] = (pin_s2_q[gi] == pin_s3_q[gi]) &&
                           (pin_s3_q[gi] != pin_f_q[gi]);
      always @(posedge ref_clk) begin
        if (rst) begin
          // reset to each pin's idle level so no false edge follows reset
          pin_s1_q[gi] <= (gi == 1);
          pin_s2_q[gi] <= (gi == 1);
          pin_s3_q[gi] <= (gi == 1);
          pin_f_q[gi] <= (gi == 1);
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
          if (pin_chg[gi])
            pin_f_q[gi] <= pin_s3_q[gi];
        end
      end
    end
  endgenerate

  wire sclk_rise = pin_chg[0] & pin_s3_q[0];
  wire sclk_fall = pin_chg[0] & ~pin_s3_q[0];
  wire cs_fall = pin_chg[1] & ~pin_s3_q[1];
  wire cs_rise = pin_chg[1] & pin_s3_q[1];
  wire cs_active = ~pin_f_q[1];
  wire sdi_f = pin_f_q[2];

  // register state
  reg [7:0] drive_mode_q;
  reg [7:0] policy_q;
  reg [2:0] lock_q;
  reg [3:0] lock_low_q;
  reg [7:0] load_cfg_q;
  reg otw_q, supply_undervoltage_flag_q, pump_undervoltage_flag_q, tsd_q;
  reg [3:0] oc_q;
  reg [1:0] ol_q;
  reg [1:0] itrip_q;
  reg global_q;

  // serial engine
  reg [15:0] in_sh_q;
  reg [15:0] out_sh_q;
  reg [4:0] bit_cnt_q;
  reg sdo_q;

  wire [7:0] status_byte = {`STATUS_TOP, otw_q, supply_undervoltage_flag_q, pump_undervoltage_flag_q, |oc_q,
                            tsd_q, |ol_q}; // R24
  wire [7:0] fault_reg = {1'b0, global_q, otw_q, supply_undervoltage_flag_q, pump_undervoltage_flag_q, |oc_q,
                          tsd_q, |ol_q}; // R02
  wire [7:0] diag_reg = {ol_q, itrip_q, oc_q}; // R03 R04 R05
  wire [7:0] lock_reg = {1'b0, lock_q, lock_low_q}; // R15

  // address bits of the command byte, read before the eighth shift lands
  wire [4:0] rd_addr = in_sh_q[4:0];
  reg [7:0] rd_data;
  always @* begin
    case (rd_addr)
      `ADDR_FAULT_SUMMARY: rd_data = fault_reg;
      `ADDR_HB_DIAG: rd_data = diag_reg;
      `ADDR_DRIVE_MODE: rd_data = drive_mode_q;
      `ADDR_PROT_POLICY: rd_data = policy_q;
      `ADDR_LOCK_DRIVE: rd_data = lock_reg;
      `ADDR_LOAD_LIMIT: rd_data = load_cfg_q;
      default: rd_data = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      in_sh_q <= 16'h0000;
      out_sh_q <= 16'h0000;
      bit_cnt_q <= 5'd0;
      sdo_q <= 1'b0;
    end else if (cs_fall) begin
      out_sh_q <= {status_byte, 8'h00}; // R24
      bit_cnt_q <= 5'd0;
    end else if (cs_active) begin
      if (sclk_rise) begin
        sdo_q <= out_sh_q[15];
        out_sh_q <= {out_sh_q[14:0], 1'b0};
      end
      if (sclk_fall) begin
        in_sh_q <= {in_sh_q[14:0], sdi_f}; // R23
        if (bit_cnt_q != 5'd31)
          bit_cnt_q <= bit_cnt_q + 5'd1;
        if (bit_cnt_q == 5'd7)
          out_sh_q[15:8] <= rd_data; // R24
      end
    end
  end

  assign sdo = sdo_q;
  assign sdo_oe_n = ~cs_active;

  // frame commit at chip-select release; wrong length frames are dropped
  wire frame_ok = cs_rise && (bit_cnt_q == `FRAME_BITS);
  wire [4:0] wr_addr = in_sh_q[`CMD_ADDR_HI:`CMD_ADDR_LO];
  wire wr_en = frame_ok && !in_sh_q[`CMD_RW_BIT] &&
               is_ctrl_addr(wr_addr); // R01 R25
  wire [7:0] wr_data = in_sh_q[7:0];
  wire locked = (lock_q == `LOCK_CODE_LOCK);
  wire clr_pulse = wr_en && (wr_addr == `ADDR_LOCK_DRIVE) &&
                   wr_data[7]; // R15

  // open load test and overcurrent retry timing
  reg [17:0] ol_cnt_q;
  reg [17:0] retry_cnt_q;
  wire [17:0] ol_target = load_cfg_q[5] ? OL_LONG_CYCLES[17:0] :
                          OL_SHORT_CYCLES[17:0]; // R20
  wire ol_done = load_cfg_q[6] && (ol_cnt_q >= ol_target - 18'd1);
  wire [17:0] retry_target = RETRY_BASE_CYCLES[17:0] << policy_q[3:2];
  wire retry_done = (policy_q[1:0] == `OCP_RETRY) && (|oc_q) &&
                    (retry_cnt_q >= retry_target - 18'd1); // R13

  always @(posedge ref_clk) begin
    if (rst) begin
      drive_mode_q <= `RST_DRIVE_MODE;
      policy_q <= `RST_PROT_POLICY;
      lock_q <= `LOCK_CODE_OPEN;
      lock_low_q <= 4'h0;
      load_cfg_q <= `RST_LOAD_LIMIT;
    end else begin
      if (wr_en && wr_addr == `ADDR_DRIVE_MODE && !locked)
        drive_mode_q <= wr_data; // R16 R06 R07 R08 R09
      if (wr_en && wr_addr == `ADDR_PROT_POLICY)
        policy_q <= wr_data;
      if (wr_en && wr_addr == `ADDR_LOCK_DRIVE) begin
        lock_q <= wr_data[6:4]; // R16
        lock_low_q <= wr_data[3:0];
      end
      if (wr_en && wr_addr == `ADDR_LOAD_LIMIT)
        load_cfg_q <= wr_data; // R21 R22
      else if (ol_done)
        load_cfg_q[6] <= 1'b0; // R19
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      ol_cnt_q <= 18'd0;
      retry_cnt_q <= 18'd0;
    end else begin
      if (load_cfg_q[6] && !ol_done)
        ol_cnt_q <= ol_cnt_q + 18'd1;
      else
        ol_cnt_q <= 18'd0;
      if ((policy_q[1:0] == `OCP_RETRY) && (|oc_q) && !retry_done)
        retry_cnt_q <= retry_cnt_q + 18'd1;
      else
        retry_cnt_q <= 18'd0;
    end
  end

  // fault flags; a new event wins over a clear in the same cycle
  wire [1:0] ol_set = (ol_done || load_cfg_q[4]) ? open_load_in : 2'b00;
  always @(posedge ref_clk) begin
    if (rst) begin
      otw_q <= 1'b0;
      supply_undervoltage_flag_q <= 1'b0;
      pump_undervoltage_flag_q <= 1'b0;
      tsd_q <= 1'b0;
      oc_q <= 4'h0;
      ol_q <= 2'b00;
      itrip_q <= 2'b00;
    end else begin
      otw_q <= overheat_warning_in;
      supply_undervoltage_flag_q <= supply_uv_in;
      pump_undervoltage_flag_q <= pump_uv_in & ~policy_q[4]; // R12
      if (policy_q[6])
        tsd_q <= thermal_in; // R11
      else
        tsd_q <= thermal_in | (tsd_q & ~clr_pulse); // R11
      case (policy_q[1:0]) // R14
        `OCP_LATCH: oc_q <= overcurrent_in | (oc_q & {4{~clr_pulse}});
        `OCP_RETRY: oc_q <= overcurrent_in |
                            (oc_q & {4{~(clr_pulse | retry_done)}});
        `OCP_REPORT: oc_q <= overcurrent_in;
        default: oc_q <= 4'h0;
      endcase
      ol_q <= ol_set | (ol_q & {2{~clr_pulse}}); // R03
      itrip_q <= regulating_in & ~{load_cfg_q[0], load_cfg_q[1]}; // R04 R22
    end
  end

  // global error and outputs
  wire global_d = supply_undervoltage_flag_q | pump_undervoltage_flag_q | tsd_q | (|oc_q) | (|ol_q) |
                  (otw_q & policy_q[5]) |
                  ((|itrip_q) & policy_q[7]); // R10
  wire in_a_f = pin_f_q[3];
  wire in_b_f = pin_f_q[4];
  wire [1:0] mode = drive_mode_q[1:0];
  wire oc_act = (|oc_q) && (policy_q[1:0] == `OCP_LATCH ||
                            policy_q[1:0] == `OCP_RETRY);

  always @(posedge ref_clk) begin
    if (rst) begin
      global_q <= 1'b0;
      error_output_pin_n <= 1'b1;
      drive_a <= 1'b0;
      drive_b <= 1'b0;
      bridge1_hiz <= 1'b0;
      bridge2_hiz <= 1'b0;
      bridge_fault_off <= 1'b0;
      bridge_mode <= `MODE_PWM;
      off_time_select <= 2'b01;
      slew_code <= 3'b100;
      trip_current_level <= 2'b10;
      regulation_enable <= 2'b11;
      active_load_test_enable <= 1'b0;
    end else begin
      global_q <= global_d; // R02
      error_output_pin_n <= ~global_d; // R02
      drive_a <= drive_mode_q[5] ? lock_low_q[1] : in_a_f; // R07 R18
      drive_b <= drive_mode_q[5] ? lock_low_q[0] : in_b_f; // R18
      bridge1_hiz <= (mode == `MODE_HIZ) ||
                     (mode == `MODE_INDEP && lock_low_q[3]); // R09 R17
      bridge2_hiz <= (mode == `MODE_HIZ) ||
                     (mode == `MODE_INDEP && lock_low_q[2]); // R17
      bridge_fault_off <= supply_undervoltage_flag_q | pump_undervoltage_flag_q | tsd_q | oc_act; // R14
      bridge_mode <= mode; // R09
      off_time_select <= drive_mode_q[7:6]; // R06
      slew_code <= drive_mode_q[4:2]; // R08
      trip_current_level <= load_cfg_q[3:2]; // R22
      regulation_enable <= ~{load_cfg_q[0], load_cfg_q[1]}; // R22
      active_load_test_enable <= load_cfg_q[4]; // R21
    end
  end

endmodule // hbridge_config_status_regs

// file: tb/hbridge_regs_asserts.sv
/*
  Port-level checks for the H-bridge register bank.
  Assumes one ref_clk domain and a synchronous active-high rst.
*/
`timescale 1ns/1ps
module hbridge_regs_asserts (
  input wire ref_clk, // clock
  input wire rst, // reset
  input wire scs_n_pin, // chip select
  input wire supply_uv_in, // supply fault
  input wire thermal_in, // shutdown fault
  input wire sdo_oe_n, // response drive enable
  input wire error_output_pin_n, // error pin
  input wire bridge1_hiz, // bridge 1 off
  input wire bridge2_hiz, // bridge 2 off
  input wire bridge_fault_off, // shutdown
  input wire [1:0] bridge_mode, // mode
  input wire [1:0] off_time_select, // off time
  input wire [2:0] slew_code, // slew
  input wire [1:0] trip_current_level, // trip level
  input wire [1:0] regulation_enable // regulated bridges
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_uv_held;
    supply_uv_in [*4];
  endsequence
  sequence s_bus_idle;
    scs_n_pin [*8];
  endsequence
  a_reset_fields: assert property ($fell(rst) |-> bridge_mode == 2'h1 &&
    off_time_select == 2'h1 && slew_code == 3'h4)
    else $error("fields not at reset values");
  a_reset_trip: assert property ($fell(rst) |-> trip_current_level == 2'h2 &&
    regulation_enable == 2'h3) else $error("trip fields not at reset values");
  a_uv_error_pin: assert property (s_uv_held |-> !error_output_pin_n)
    else $error("error pin high during supply fault");
  a_uv_shutdown: assert property (s_uv_held |-> bridge_fault_off)
    else $error("bridge on during supply fault");
  a_thermal_shutdown: assert property (thermal_in [*4] |-> bridge_fault_off)
    else $error("bridge on during thermal fault");
  a_hiz_mode_off: assert property ((bridge_mode == 2'h3) [*2] |->
    bridge1_hiz && bridge2_hiz) else $error("bridge driven in off mode");
  a_hiz_pair_modes: assert property ((bridge_mode < 2'h2) [*2] |->
    !bridge1_hiz && !bridge2_hiz) else $error("bridge off outside split mode");
  a_sdo_released: assert property (scs_n_pin [*6] |-> sdo_oe_n)
    else $error("response driven without chip select");
  a_config_quiet: assert property (s_bus_idle |-> $stable(slew_code) &&
    $stable(bridge_mode)) else $error("settings moved with bus idle");
endmodule // hbridge_regs_asserts

bind hbridge_config_status_regs hbridge_regs_asserts u_chk (.*);

// file: tb/hbridge_spi_master.sv
/*
  Serial bus master model for the register bank's slave port.
  Assumes ref_clk at 40 MHz; link clock phases of four cycles (100 ns).
*/
`timescale 1ns/1ps
module hbridge_spi_master (
  input wire ref_clk, // pacing clock
  output reg scs_n_pin, // chip select, active low
  output reg sclk_pin, // link clock, idle low
  output reg sdi_pin, // command bits
  input wire sdo, // response bits
  input wire sdo_oe_n // response enable, low while driving
);
  integer b;
  initial begin
    scs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    sdi_pin = 1'b0;
  end
  task xfer(input [15:0] w, output [15:0] r);
    begin
      @(negedge ref_clk);
      scs_n_pin = 1'b0;
      repeat (4) @(negedge ref_clk);
      for (b = 15; b >= 0; b = b - 1) begin
        sclk_pin = 1'b1;
        sdi_pin = w[b];
        repeat (4) @(negedge ref_clk);
        r[b] = sdo_oe_n ? 1'bx : sdo;
        sclk_pin = 1'b0;
        repeat (4) @(negedge ref_clk);
      end
      scs_n_pin = 1'b1;
      // line no longer qualified: show the inverse
      sdi_pin = ~sdi_pin;
      repeat (20) @(negedge ref_clk);
    end
  endtask
endmodule // hbridge_spi_master

// file: tb/hbridge_config_status_regs_test.sv
/*
  Self-checking bench for the H-bridge register bank.
  Assumes the master model and checker files are compiled first.
*/
`timescale 1ns/1ps
module hbridge_config_status_regs_test;
  reg ref_clk = 0, rst = 1, in_a_pin = 0, in_b_pin = 0;
  reg overheat_warning_in = 0, supply_uv_in = 0, pump_uv_in = 0;
  reg thermal_in = 0;
  reg [3:0] overcurrent_in = 0;
  reg [1:0] open_load_in = 0, regulating_in = 0;
  wire scs_n_pin, sclk_pin, sdi_pin, sdo, sdo_oe_n, error_output_pin_n;
  wire drive_a, drive_b, bridge1_hiz, bridge2_hiz, bridge_fault_off;
  wire active_load_test_enable;
  wire [1:0] bridge_mode, off_time_select, trip_current_level;
  wire [1:0] regulation_enable;
  wire [2:0] slew_code;
  integer n_errors = 0, compares = 0, seed = 77, i, k;
  reg [7:0] mdl [0:7];
  reg [15:0] resp;
  reg [7:0] v;
  initial forever #12.5 ref_clk = ~ref_clk;
  hbridge_config_status_regs #(.RETRY_BASE_CYCLES(8), .OL_SHORT_CYCLES(6),
    .OL_LONG_CYCLES(24)) dut_u (.*);
  hbridge_spi_master host_u (.ref_clk(ref_clk), .scs_n_pin(scs_n_pin),
    .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
  task results;
    begin
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [63:0] name, input [7:0] exp, input [7:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0s exp %h got %h", name, exp, got);
      end
    end
  endtask
  task xf(input [15:0] w, input [4:0] a);
    begin
      host_u.xfer(w, resp);
      chk("status", {2'b11, mdl[0][5:0]}, resp[15:8]);
      chk("report", mdl[a], resp[7:0]);
    end
  endtask
  task rd(input [4:0] a);
    xf({2'b01, a, 9'h000}, a);
  endtask
  task wr(input [4:0] a, input [7:0] d);
    begin
      xf({2'b00, a, 1'b0, d}, a);
      if (a > 1 && a < 6 && !(a == 2 && mdl[4][6:4] == 3'h3)) mdl[a] = d;
      mdl[4][7] = 1'b0;
    end
  endtask
  initial begin
    for (i = 0; i < 8; i = i + 1)
      mdl[i] = 8'h00;
    mdl[2] = 8'h51;
    mdl[3] = 8'h0c;
    mdl[4] = 8'h40;
    mdl[5] = 8'h08;
    repeat (6) @(negedge ref_clk);
    rst = 0;
    repeat (6) @(negedge ref_clk);
    for (i = 0; i < 7; i = i + 1)
      rd(i[4:0]);
    $display("done reset values");
    for (k = 0; k < 12; k = k + 1) begin
      i = 2 + k % 4;
      v = $random(seed);
      if (i == 4) v = {1'b0, 3'h4, v[3:0]};
      if (i == 5) v[6] = 1'b0;
      wr(i[4:0], v);
      rd(i[4:0]);
      if (i == 5) chk("regen", {6'h0, ~v[0], ~v[1]}, {6'h0, regulation_enable});
      if (i == 2) chk("slew", {5'h0, v[4:2]}, {5'h0, slew_code});
    end
    for (k = 0; k < 3; k = k + 1) begin
      wr((k == 2) ? 5'd6 : k[4:0], 8'hff);
      rd((k == 2) ? 5'd6 : k[4:0]);
    end
    $display("done random and refused writes");
    wr(5'd4, 8'h30);
    wr(5'd2, 8'h2e);
    wr(5'd4, 8'h40);
    wr(5'd2, 8'h51);
    rd(5'd2);
    $display("done lock");
    wr(5'd4, 8'h4a);
    in_b_pin = 1;
    for (k = 0; k < 4; k = k + 1) begin
      wr(5'd2, 8'h70 | k[7:0]);
      chk("mode", k[7:0], {6'h0, bridge_mode});
      chk("hiz", (k > 1) ? k[7:0] : 8'h0, {6'h0, bridge1_hiz, bridge2_hiz});
      chk("soft", 8'h2, {6'h0, drive_a, drive_b});
    end
    wr(5'd2, 8'h51);
    chk("pins", 8'h1, {6'h0, drive_a, drive_b});
    $display("done drive modes");
    wr(5'd3, 8'h0c);
    wr(5'd5, 8'h10);
    supply_uv_in = 1;
    overcurrent_in = 4'b1000;
    regulating_in = 2'b01;
    open_load_in = 2'b10;
    repeat (4) @(negedge ref_clk);
    chk("errpin", 8'h0, {7'h0, error_output_pin_n});
    mdl[0] = 8'h55;
    mdl[1] = 8'h98;
    rd(5'd0);
    rd(5'd1);
    supply_uv_in = 0;
    overcurrent_in = 0;
    regulating_in = 0;
    open_load_in = 0;
    repeat (4) @(negedge ref_clk);
    mdl[0] = 8'h45;
    mdl[1] = 8'h88;
    rd(5'd0);
    rd(5'd1);
    wr(5'd4, 8'hc0);
    mdl[0] = 8'h00;
    mdl[1] = 8'h00;
    rd(5'd0);
    rd(5'd4);
    for (k = 0; k < 2; k = k + 1) begin
      wr(5'd3, {1'b0, k[0], 6'h0c});
      thermal_in = 1;
      repeat (6) @(negedge ref_clk);
      thermal_in = 0;
      repeat (4) @(negedge ref_clk);
      mdl[0] = k ? 8'h00 : 8'h42;
      rd(5'd0);
      wr(5'd4, 8'hc0);
      mdl[0] = 8'h00;
    end
    overheat_warning_in = 1;
    repeat (4) @(negedge ref_clk);
    mdl[0] = 8'h20;
    rd(5'd0);
    wr(5'd3, 8'h2c);
    mdl[0] = 8'h60;
    rd(5'd0);
    chk("warnpin", 8'h0, {7'h0, error_output_pin_n});
    overheat_warning_in = 0;
    repeat (4) @(negedge ref_clk);
    mdl[0] = 8'h00;
    $display("done faults");
    wr(5'd5, 8'h40);
    resp = 16'hffff;
    for (k = 0; k < 10 && resp[6] !== 1'b0; k = k + 1)
      host_u.xfer(16'h4a00, resp);
    if (k == 10) begin
      n_errors = n_errors + 1;
      results;
    end
    mdl[5] = 8'h00;
    rd(5'd5);
    $display("done load test");
    results;
  end
endmodule // hbridge_config_status_regs_test
